// ==== logic/rxe_status.sv ====
// Contract
// - Status view is read-only; writes only clear
// - Overrun flag bit 3 on full FIFO
// - Overrun keeps FIFO contents, drops new character
// - Break flag bit 2 after long low
// - Break pushes exactly one zero character
// - After break, wait idle then start bit
// - With FIFO, errors follow FIFO head character
// - Parity flag bit 1 from line control
// - Framing flag bit 0 on low stop
// - Any clear write zeroes all four flags; a flag set in the same cycle stays set
// - Status gathers flags of characters read out with FIFO, of characters as received without
// - Overrun flag asserts immediately
//
// The APB register port was decided locally.
`include "rxe_map.svh"

module rxe_status
  import rxe_pkg::*;
#(
  parameter int BIT_CYCLES = `RXE_BIT_CYCLES,
  parameter int CHAR_BITS = `RXE_CHAR_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RXE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  input wire rxe_char_s rx_char,
  input wire logic [7:0] line_control_reg,
  input wire logic fifo_full,
  output logic fifo_push,
  output rxe_entry_s fifo_wdata,
  input wire logic data_reg_read,
  input wire rxe_entry_s fifo_head,
  output logic rx_accept,
  output logic [3:0] rx_error_status
);

  localparam int BREAK_CYCLES = BIT_CYCLES * CHAR_BITS;

  // Break counter is 16 bits wide
  if (BIT_CYCLES < 1 || CHAR_BITS < 1 || BREAK_CYCLES > 65535) begin : g_bad_break
    $error("rxe_status: break length out of range");
  end

  rxe_state_s r;
  rxe_state_s n;
  logic fen;
  logic exp_par;
  logic char_ok;
  logic brk_evt;
  logic new_evt;
  logic clear;
  rxe_entry_s entry;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.push = 1'b0;
    n.line_meta = rx_line;
    n.line_sync = r.line_meta;
    fen = line_control_reg[`RXE_LCR_FIFO_EN];

    // APB: answer in the cycle after setup, so pready stands one cycle
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = (paddr != `RXE_OFF_STATUS);
      // Reserved bits read as zero
      n.prdata = (paddr == `RXE_OFF_STATUS && !pwrite) ? {28'h0, r.flags} : 32'h0;
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    // Write data is ignored: any value clears
    clear = psel && penable && r.pready && pwrite && !r.pslverr;

    // Parity expected on the line
    if (line_control_reg[`RXE_LCR_STICK]) begin
      exp_par = ~line_control_reg[`RXE_LCR_EVEN];
    end else if (line_control_reg[`RXE_LCR_EVEN]) begin
      exp_par = ^rx_char.data;
    end else begin
      exp_par = ~^rx_char.data;
    end

    char_ok = rx_char.data_valid && (r.state == RXE_ACCEPT);
    brk_evt = (r.state == RXE_ACCEPT) && !r.line_sync &&
              (r.low_cnt == 16'(BREAK_CYCLES - 1));

    entry = '0;
    if (brk_evt) begin
      entry.brk = 1'b1;
      entry.data = 8'h00;
    end else if (char_ok) begin
      entry.data = rx_char.data;
      entry.par = line_control_reg[`RXE_LCR_PAR_EN] && (rx_char.parity_bit != exp_par);
      entry.frm = !rx_char.stop_bit;
    end
    new_evt = brk_evt || char_ok;

    // Break tracking
    case (r.state)
      RXE_ACCEPT: begin
        if (brk_evt) begin
          n.state = RXE_HOLD;
          n.low_cnt = 16'h0;
        end else if (!r.line_sync) begin
          n.low_cnt = r.low_cnt + 16'h1;
        end else begin
          n.low_cnt = 16'h0;
        end
      end
      RXE_HOLD: begin
        if (r.line_sync) begin
          n.state = RXE_ARMED;
        end
      end
      RXE_ARMED: begin
        if (!r.line_sync) begin
          n.state = RXE_ACCEPT;
          n.low_cnt = 16'h1;
        end
      end
      default: begin
        n.state = RXE_ACCEPT;
        n.low_cnt = 16'h0;
      end
    endcase

    // Full FIFO: queued data stays, the new character is lost
    if (new_evt && !fifo_full) begin
      n.push = 1'b1;
      n.wdata = entry;
    end

    // Clear first so that a same-cycle set survives
    if (clear) begin
      n.flags = `RXE_STATUS_RESET;
    end
    if (new_evt && fifo_full) begin
      n.flags[`RXE_BIT_OVERRUN] = 1'b1;
    end
    if (fen) begin
      if (data_reg_read) begin
        n.flags[`RXE_BIT_BREAK] = n.flags[`RXE_BIT_BREAK] | fifo_head.brk;
        n.flags[`RXE_BIT_PARITY] = n.flags[`RXE_BIT_PARITY] | fifo_head.par;
        n.flags[`RXE_BIT_FRAMING] = n.flags[`RXE_BIT_FRAMING] | fifo_head.frm;
      end
    end else if (new_evt) begin
      n.flags[`RXE_BIT_BREAK] = n.flags[`RXE_BIT_BREAK] | entry.brk;
      n.flags[`RXE_BIT_PARITY] = n.flags[`RXE_BIT_PARITY] | entry.par;
      n.flags[`RXE_BIT_FRAMING] = n.flags[`RXE_BIT_FRAMING] | entry.frm;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: RXE_ACCEPT, low_cnt: 16'h0, flags: `RXE_STATUS_RESET,
             push: 1'b0, wdata: '0, pready: 1'b0, pslverr: 1'b0,
             prdata: 32'h0, line_meta: 1'b1, line_sync: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign fifo_push = r.push;
  assign fifo_wdata = r.wdata;
  // One-hot: bit 0 is the accepting state, so no decode after the flop
  assign rx_accept = r.state[0];
  assign rx_error_status = r.flags;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready not one cycle");

  property p_overrun_set;
    new_evt && fifo_full |=> rx_error_status[`RXE_BIT_OVERRUN];
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not set");

  property p_overrun_nopush;
    new_evt && fifo_full |=> !fifo_push;
  endproperty
  a_overrun_nopush: assert property (p_overrun_nopush) else $error("push on full");

  property p_break_push;
    brk_evt && !fifo_full |=> fifo_push && fifo_wdata.brk && fifo_wdata.data == 8'h00
      ##1 !fifo_push;
  endproperty
  a_break_push: assert property (p_break_push) else $error("break push wrong");

  property p_break_wait;
    !rx_accept && rx_char.data_valid |=> !fifo_push;
  endproperty
  a_break_wait: assert property (p_break_wait) else $error("char taken after break");

  property p_clear;
    clear && !new_evt && !(fen && data_reg_read) |=> rx_error_status == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_read_view;
    s_setup ##0 (paddr == `RXE_OFF_STATUS && !pwrite) |=> prdata == {28'h0, $past(r.flags)};
  endproperty
  a_read_view: assert property (p_read_view) else $error("status read wrong");

  property p_parity;
    !fen && char_ok && line_control_reg[`RXE_LCR_PAR_EN] && rx_char.parity_bit != exp_par
      |=> rx_error_status[`RXE_BIT_PARITY];
  endproperty
  a_parity: assert property (p_parity) else $error("parity not set");

  property p_framing;
    !fen && char_ok && !rx_char.stop_bit |=> rx_error_status[`RXE_BIT_FRAMING];
  endproperty
  a_framing: assert property (p_framing) else $error("framing not set");

  property p_head;
    fen && data_reg_read && fifo_head.brk |=> rx_error_status[`RXE_BIT_BREAK];
  endproperty
  a_head: assert property (p_head) else $error("head status lost");

  property p_write_only_clears;
    !clear && !new_evt && !(fen && data_reg_read) |=> $stable(rx_error_status);
  endproperty
  a_write_only_clears: assert property (p_write_only_clears) else $error("flags moved");

endmodule

// ==== logic/rxe_map.svh ====
`ifndef RXE_MAP_SVH
`define RXE_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RXE_OFF_STATUS 12'h004
`define RXE_ADDR_W 12

// ----------------------------------------
// Status view field positions
// ----------------------------------------
`define RXE_BIT_OVERRUN 3
`define RXE_BIT_BREAK 2
`define RXE_BIT_PARITY 1
`define RXE_BIT_FRAMING 0
`define RXE_STATUS_RESET 4'h0

// ----------------------------------------
// Line control field positions
// ----------------------------------------
`define RXE_LCR_PAR_EN 1
`define RXE_LCR_EVEN 2
`define RXE_LCR_FIFO_EN 4
`define RXE_LCR_STICK 7

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define RXE_BIT_CYCLES 16
`define RXE_CHAR_BITS 11

`endif

// ==== logic/rxe_pkg.sv ====
package rxe_pkg;

  typedef enum logic [2:0] {
    RXE_ACCEPT = 3'b001,
    RXE_HOLD = 3'b010,
    RXE_ARMED = 3'b100
  } rxe_state_e;

  typedef struct packed {
    logic brk;
    logic par;
    logic frm;
    logic [7:0] data;
  } rxe_entry_s;

  typedef struct packed {
    logic data_valid;
    logic [7:0] data;
    logic parity_bit;
    logic stop_bit;
  } rxe_char_s;

  typedef struct packed {
    rxe_state_e state;
    logic [15:0] low_cnt;
    logic [3:0] flags;
    logic push;
    rxe_entry_s wdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic line_meta;
    logic line_sync;
  } rxe_state_s;

endpackage

// ==== testbench/rxe_far_tx.sv ====
module rxe_far_tx (
  input wire logic pclk,
  input wire logic brk_req,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Remote transmitter line
  // ----------------------------------------
  // Marking level when idle; low only while a break is asked for
  initial rx_line = 1'h1;
  always @(posedge pclk) begin
    rx_line <= ~brk_req;
  end
endmodule

// ==== testbench/tb_top.sv ====
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rxe_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rx_line, fifo_push, rx_accept;
  logic brk_req = 1'h0;
  logic fifo_full = 1'h0;
  logic data_reg_read = 1'h0;
  logic [7:0] line_control_reg = 8'h06;
  rxe_char_s rx_char = '0;
  rxe_entry_s fifo_wdata, last_w;
  rxe_entry_s fifo_head = '0;
  logic [3:0] status;
  int n_errors = 0;
  int compares = 0;
  int n_push = 0;
  int cyc = 0;
  int p0;

  always #20 pclk = ~pclk;

  rxe_status #(.BIT_CYCLES(2), .CHAR_BITS(11)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .rx_char(rx_char), .line_control_reg(line_control_reg),
    .fifo_full(fifo_full), .fifo_push(fifo_push), .fifo_wdata(fifo_wdata),
    .data_reg_read(data_reg_read), .fifo_head(fifo_head), .rx_accept(rx_accept),
    .rx_error_status(status)
  );

  rxe_far_tx far (.pclk(pclk), .brk_req(brk_req), .rx_line(rx_line));

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic close_out();
    $display("Compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (fifo_push === 1'h1) begin
      n_push++;
      last_w = fifo_wdata;
    end
    if (cyc == 4000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // Bus and line drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h000000a5;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic send(input logic [7:0] d, input logic pb, input logic sb);
    @(posedge pclk);
    rx_char <= '{1'h1, d, pb, sb};
    @(posedge pclk);
    rx_char <= '0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic clr();
    apb(1'h1, 12'h004);
    @(posedge pclk);
    `CHK("cleared", 4'h0, status)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'h0, 12'h004);
    `CHK("reset read", 32'h0, rd)
    `CHK("accept", 1'h1, rx_accept)
    apb(1'h0, 12'h008);
    `CHK("unmapped", 1'h1, err)
    $display("reset test done");
  endtask

  task automatic t_flags();
    send(8'h01, 1'h1, 1'h0);
    `CHK("framing", 4'h1, status)
    `CHK("push entry", 11'h101, last_w)
    clr();
    send(8'h01, 1'h0, 1'h1);
    `CHK("parity", 4'h2, status)
    apb(1'h1, 12'h004);
    apb(1'h0, 12'h004);
    `CHK("write no store", 32'h0, rd)
    line_control_reg <= 8'h02;
    send(8'h03, 1'h1, 1'h1);
    `CHK("odd parity", 4'h0, status)
    line_control_reg <= 8'h86;
    send(8'h03, 1'h1, 1'h1);
    `CHK("stick parity", 4'h2, status)
    line_control_reg <= 8'h06;
    clr();
    $display("flag test done");
  endtask

  task automatic t_overrun();
    fifo_full <= 1'h1;
    p0 = n_push;
    send(8'h55, 1'h0, 1'h1);
    `CHK("overrun", 4'h8, status)
    `CHK("no push", 0, n_push - p0)
    fifo_full <= 1'h0;
    clr();
    $display("overrun test done");
  endtask

  task automatic t_break();
    p0 = n_push;
    brk_req <= 1'h1;
    repeat (15) @(posedge pclk);
    `CHK("early", 0, n_push - p0)
    repeat (40) @(posedge pclk);
    `CHK("one zero", 1, n_push - p0)
    `CHK("zero char", 9'h100, {last_w.brk, last_w.data})
    `CHK("break", 4'h4, status)
    `CHK("locked", 1'h0, rx_accept)
    brk_req <= 1'h0;
    repeat (4) @(posedge pclk);
    send(8'h55, 1'h0, 1'h1);
    `CHK("dropped", 1, n_push - p0)
    brk_req <= 1'h1;
    @(posedge pclk);
    brk_req <= 1'h0;
    repeat (5) @(posedge pclk);
    `CHK("rearmed", 1'h1, rx_accept)
    clr();
    $display("break test done");
  endtask

  task automatic t_fifo();
    line_control_reg <= 8'h16;
    send(8'h01, 1'h1, 1'h0);
    `CHK("head only", 4'h0, status)
    data_reg_read <= 1'h1;
    fifo_head <= '{1'h0, 1'h0, 1'h1, 8'h00};
    @(posedge pclk);
    data_reg_read <= 1'h0;
    repeat (2) @(posedge pclk);
    apb(1'h0, 12'h004);
    `CHK("head read", 32'h1, rd)
    $display("fifo test done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_flags();
    t_overrun();
    t_break();
    t_fifo();
    close_out();
  end
endmodule
